// ==== rtl/machine_cycle_timer.sv ====
// twelve-phase machine cycle sequencer with latch and fetch strobes
// assumes one phase per enabled clock edge
`timescale 1ns/1ps
module machine_cycle_timer
	import xmap_pkg::*;
(
	input  wire logic       clk_sys,
	input  wire logic       rst_n,
	input  wire logic       clk_en,
	input  wire logic       two_byte_op,
	output logic [3:0]      phase,
	output logic            ale,
	output logic            opcode_latch,
	output logic            operand_fetch,
	output logic            pc_advance,
	output logic            cycle_end
);
	logic [3:0] phase_d;
	assign phase_d = (phase == PH_S6P2) ? 4'h0 : phase + 4'h1;

	// strobes are decoded from the next phase so they line up with it
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			phase         <= 4'h0;
			ale           <= 1'b0;
			opcode_latch  <= 1'b0;
			operand_fetch <= 1'b0;
			pc_advance    <= 1'b0;
			cycle_end     <= 1'b0;
		end else if (clk_en) begin
			phase         <= phase_d;
			ale           <= phase_d == PH_S1P2 || phase_d == PH_S2P1
				|| phase_d == PH_S4P2 || phase_d == PH_S5P1;
			opcode_latch  <= phase_d == PH_S1P2;
			operand_fetch <= phase_d == PH_S4P1;
			// a discarded one-byte fetch leaves the counter alone
			pc_advance    <= phase_d == PH_S4P1 && two_byte_op;
			cycle_end     <= phase_d == PH_S6P2;
		end
	end

	a_phase_wrap: assert property (@(posedge clk_sys) disable iff (!rst_n)
		clk_en && phase == PH_S6P2 |=> phase == 4'h0)
		else $error("phase did not wrap after S6P2");
	a_ale_pattern: assert property (@(posedge clk_sys) disable iff (!rst_n)
		ale == (phase == PH_S1P2 || phase == PH_S2P1
		|| phase == PH_S4P2 || phase == PH_S5P1))
		else $error("ale out of step with phase");
	a_onebyte_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
		$past(clk_en) && operand_fetch |->
		pc_advance == $past(two_byte_op))
		else $error("pc advanced on discarded fetch");
endmodule : machine_cycle_timer

// ==== rtl/on_chip_xdata_ram_access_memory_map.sv ====
// address decoding, internal ram, stack and external-data routing
// assumes a cpu on clk_sys drives the request ports; pins are async
`timescale 1ns/1ps
module on_chip_xdata_ram_access_memory_map
	import xmap_pkg::*;
#(
	parameter int ON_CHIP_XDATA_RAM_DEPTH = 2048,
	parameter int STROBE_LEN = STROBE_CYC
) (
	input  wire logic        clk_sys,
	input  wire logic        rst_n,
	input  wire logic        clk_en,
	input  wire logic        external_access_pin,
	input  wire logic [15:0] pc,
	input  wire logic        two_byte_op,
	output logic             code_from_external,
	output logic             ale,
	output logic             opcode_latch,
	output logic             operand_fetch,
	output logic             pc_advance,
	output logic             cycle_end,
	input  wire logic        ram_valid,
	input  wire logic        ram_write,
	input  wire ram_mode_t   ram_mode,
	input  wire logic [7:0]  ram_addr,
	input  wire logic [7:0]  ram_wdata,
	input  wire logic        ram_bit_value,
	input  wire logic        stack_push,
	input  wire logic        stack_pop,
	input  wire logic [7:0]  stack_wdata,
	input  wire logic        muldiv_wr,
	input  wire logic [7:0]  muldiv_b,
	output logic [7:0]       ram_rdata,
	output logic             ram_rvalid,
	output logic             ram_fault,
	output logic [7:0]       b_value,
	input  wire logic        xmove_valid,
	input  wire logic        xmove_write,
	input  wire logic [15:0] xmove_addr,
	input  wire logic [7:0]  xmove_wdata,
	output logic [7:0]       xmove_rdata,
	output logic             xmove_done,
	output logic             ext_rd_n,
	output logic             ext_wr_n,
	output logic [7:0]       p0_out,
	output logic             p0_oe,
	input  wire logic [7:0]  p0_in,
	output logic [7:0]       p2_out,
	output logic             p2_oe
);
	// ---------------------------------------------------------------
	// machine cycle and code space
	// ---------------------------------------------------------------
	machine_cycle_timer u_timer (
		.clk_sys       (clk_sys),
		.rst_n         (rst_n),
		.clk_en        (clk_en),
		.two_byte_op   (two_byte_op),
		.phase         (),
		.ale           (ale),
		.opcode_latch  (opcode_latch),
		.operand_fetch (operand_fetch),
		.pc_advance    (pc_advance),
		.cycle_end     (cycle_end)
	);

	// three-stage pin capture; a change counts once stages two and
	// three agree, so one glitchy sample never flips the fetch source
	logic       ea_s1_q, ea_s2_q, ea_s3_q, ea_q;
	logic [7:0] p0_s1_q, p0_s2_q, p0_s3_q, p0_f_q;
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			ea_s1_q <= 1'b0;
			ea_s2_q <= 1'b0;
			ea_s3_q <= 1'b0;
			ea_q    <= 1'b0;
			p0_s1_q <= 8'h00;
			p0_s2_q <= 8'h00;
			p0_s3_q <= 8'h00;
			p0_f_q  <= 8'h00;
		end else if (clk_en) begin
			ea_s1_q <= external_access_pin;
			ea_s2_q <= ea_s1_q;
			ea_s3_q <= ea_s2_q;
			if (ea_s2_q == ea_s3_q) begin
				ea_q <= ea_s3_q;
			end
			p0_s1_q <= p0_in;
			p0_s2_q <= p0_s1_q;
			p0_s3_q <= p0_s2_q;
			if (p0_s2_q == p0_s3_q) begin
				p0_f_q <= p0_s3_q;
			end
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			code_from_external <= 1'b1;
		end else if (clk_en) begin
			code_from_external <= !ea_q || pc > ROM_TOP;
		end
	end

	// ---------------------------------------------------------------
	// special registers
	// ---------------------------------------------------------------
	logic       dis_q, vis_q;
	logic [7:0] psw_q, sp_q;
	logic       stack_go, ram_go, sfr_wr;
	assign stack_go = clk_en && (stack_push || stack_pop);
	assign ram_go   = clk_en && ram_valid && !stack_go;
	assign sfr_wr   = ram_go && ram_write && ram_mode == AM_DIRECT
		&& ram_addr[7];

	// the disable bit can only be cleared by software; a write of one
	// is dropped so noise or a runaway program cannot unmap the ram
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			dis_q <= SYSTEM_CONTROL_RESET[XD_BIT];
			vis_q <= SYSTEM_CONTROL_RESET[XV_BIT];
		end else if (sfr_wr && ram_addr == SYSTEM_CONTROL_ADDR) begin
			dis_q <= dis_q & ram_wdata[XD_BIT];
			vis_q <= ram_wdata[XV_BIT];
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			psw_q <= PSW_RESET;
		end else if (sfr_wr && ram_addr == PSW_ADDR) begin
			psw_q <= ram_wdata;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			sp_q <= SP_RESET;
		end else if (clk_en && stack_push) begin
			sp_q <= sp_q + 8'h01;
		end else if (clk_en && stack_pop) begin
			sp_q <= sp_q - 8'h01;
		end else if (sfr_wr && ram_addr == SP_ADDR) begin
			sp_q <= ram_wdata;
		end
	end

	// arithmetic results take priority over a scratch write
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			b_value <= B_RESET;
		end else if (clk_en && muldiv_wr) begin
			b_value <= muldiv_b;
		end else if (sfr_wr && ram_addr == B_ADDR) begin
			b_value <= ram_wdata;
		end
	end

	// ---------------------------------------------------------------
	// internal data ram
	// ---------------------------------------------------------------
	logic [7:0] iram_q [0:IRAM_DEPTH-1];
	logic [1:0] bank;
	logic [7:0] ptr_idx, eff, cur, bit_byte, sfr_rd;
	logic       sfr_hit, bad, sfr_known;
	always_comb begin
		bank    = psw_q[BANK_HI:BANK_LO];
		ptr_idx = {3'b000, bank, 2'b00, ram_addr[0]};
		eff     = ram_addr;
		sfr_hit = 1'b0;
		bad     = 1'b0;
		case (ram_mode)
			AM_DIRECT: begin
				sfr_hit = ram_addr[7];
			end
			AM_INDIRECT: begin
				eff = iram_q[ptr_idx];
			end
			AM_REGISTER: begin
				eff = {3'b000, bank, ram_addr[2:0]};
			end
			AM_BIT: begin
				eff = BIT_BASE + {4'h0, ram_addr[6:3]};
				bad = ram_addr[7];
			end
			default: begin
				bad = 1'b1;
			end
		endcase
		cur      = iram_q[eff];
		bit_byte = cur;
		bit_byte[ram_addr[2:0]] = ram_bit_value;
		sfr_rd    = 8'h00;
		sfr_known = 1'b1;
		case (ram_addr)
			SYSTEM_CONTROL_ADDR: begin
				sfr_rd[XD_BIT] = dis_q;
				sfr_rd[XV_BIT] = vis_q;
			end
			PSW_ADDR: begin
				sfr_rd = psw_q;
			end
			SP_ADDR: begin
				sfr_rd = sp_q;
			end
			B_ADDR: begin
				sfr_rd = b_value;
			end
			default: begin
				sfr_known = 1'b0;
			end
		endcase
	end

	// storage has no reset; contents are undefined after power-up
	always_ff @(posedge clk_sys) begin
		if (clk_en && stack_push) begin
			iram_q[sp_q + 8'h01] <= stack_wdata;
		end else if (ram_go && ram_write && !sfr_hit && !bad) begin
			iram_q[eff] <= (ram_mode == AM_BIT) ? bit_byte : ram_wdata;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			ram_rdata  <= 8'h00;
			ram_rvalid <= 1'b0;
			ram_fault  <= 1'b0;
		end else if (clk_en) begin
			ram_rvalid <= (stack_pop && !stack_push)
				|| (ram_go && !ram_write);
			ram_fault  <= ram_go && (bad || (sfr_hit && !sfr_known));
			if (stack_pop && !stack_push) begin
				ram_rdata <= iram_q[sp_q];
			end else if (ram_go && !ram_write) begin
				if (sfr_hit) begin
					ram_rdata <= sfr_rd;
				end else if (ram_mode == AM_BIT) begin
					ram_rdata <= {7'h00, cur[ram_addr[2:0]]};
				end else begin
					ram_rdata <= cur;
				end
			end
		end
	end

	// ---------------------------------------------------------------
	// external data moves
	// ---------------------------------------------------------------
	on_chip_xdata_ram_if #(.AW(ON_CHIP_XDATA_RAM_AW)) xr ();
	on_chip_xdata_ram_store #(.DEPTH(ON_CHIP_XDATA_RAM_DEPTH)) u_on_chip_xdata_ram (
		.clk_sys (clk_sys),
		.clk_en  (clk_en),
		.xr      (xr.store)
	);

	xbus_state_t xst_q;
	logic [15:0] xaddr_q;
	logic [7:0]  xwdata_q;
	logic        xwe_q, int_q, show_q;
	logic [3:0]  cnt_q;
	logic        in_range, hit;
	assign in_range = xmove_addr >= ON_CHIP_XDATA_RAM_BASE;
	assign hit      = in_range && !dis_q;

	assign xr.en    = xst_q == X_ADDR && int_q;
	assign xr.we    = xwe_q;
	assign xr.addr  = xaddr_q[ON_CHIP_XDATA_RAM_AW-1:0];
	assign xr.wdata = xwdata_q;

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			xst_q       <= X_IDLE;
			xaddr_q     <= 16'h0000;
			xwdata_q    <= 8'h00;
			xwe_q       <= 1'b0;
			int_q       <= 1'b0;
			show_q      <= 1'b0;
			cnt_q       <= 4'h0;
			xmove_rdata <= 8'h00;
			xmove_done  <= 1'b0;
			ext_rd_n    <= 1'b1;
			ext_wr_n    <= 1'b1;
			p0_out      <= 8'h00;
			p0_oe       <= 1'b0;
			p2_out      <= 8'h00;
			p2_oe       <= 1'b0;
		end else if (clk_en) begin
			xmove_done <= 1'b0;
			case (xst_q)
				X_IDLE: begin
					if (xmove_valid) begin
						xaddr_q  <= xmove_addr;
						xwdata_q <= xmove_wdata;
						xwe_q    <= xmove_write;
						int_q    <= hit;
						// visibility only matters on an on_chip_xdata_ram hit
						show_q   <= !hit || vis_q;
						p0_out   <= xmove_addr[7:0];
						p2_out   <= xmove_addr[15:8];
						p0_oe    <= !hit || vis_q;
						p2_oe    <= !hit || vis_q;
						xst_q    <= X_ADDR;
					end
				end
				X_ADDR: begin
					if (show_q) begin
						ext_rd_n <= xwe_q;
						ext_wr_n <= !xwe_q;
						p0_out   <= xwdata_q;
						p0_oe    <= xwe_q;
						cnt_q    <= 4'(STROBE_LEN - 1);
						xst_q    <= X_STRB;
					end else begin
						xst_q <= X_DONE;
					end
				end
				X_STRB: begin
					if (int_q && !xwe_q) begin
						p0_out <= xr.rdata;
						p0_oe  <= 1'b1;
					end
					if (cnt_q == 4'h0) begin
						ext_rd_n <= 1'b1;
						ext_wr_n <= 1'b1;
						p0_oe    <= 1'b0;
						p2_oe    <= 1'b0;
						xst_q    <= X_DONE;
					end else begin
						cnt_q <= cnt_q - 4'h1;
					end
				end
				X_DONE: begin
					xmove_rdata <= int_q ? xr.rdata : p0_f_q;
					xmove_done  <= 1'b1;
					xst_q       <= X_IDLE;
				end
				default: begin
					xst_q <= X_IDLE;
				end
			endcase
		end
	end

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	sequence s_quiet3;
		(ext_rd_n && ext_wr_n && !p0_oe && !p2_oe) [*3];
	endsequence
	sequence s_strobe_rd;
		!ext_rd_n && ext_wr_n && p2_oe;
	endsequence

	a_disable_sticky: assert property (@(posedge clk_sys)
		disable iff (!rst_n) !dis_q |=> !dis_q)
		else $error("disable bit set again after clear");
	a_disable_cause: assert property (@(posedge clk_sys)
		disable iff (!rst_n) $fell(dis_q) |->
		$past(sfr_wr && ram_addr == SYSTEM_CONTROL_ADDR))
		else $error("disable bit cleared without a write");
	a_hidden_quiet: assert property (@(posedge clk_sys)
		disable iff (!rst_n) clk_en && xst_q == X_IDLE && xmove_valid
		&& hit && !vis_q |=> s_quiet3)
		else $error("strobe on hidden on_chip_xdata_ram access");
	a_visible_read: assert property (@(posedge clk_sys)
		disable iff (!rst_n) clk_en && xst_q == X_ADDR && int_q
		&& show_q && !xwe_q |=> s_strobe_rd)
		else $error("visible on_chip_xdata_ram read not strobed");
	a_ext_when_off: assert property (@(posedge clk_sys)
		disable iff (!rst_n) clk_en && xst_q == X_IDLE && xmove_valid
		&& xmove_write && dis_q ##1 clk_en |=> !ext_wr_n)
		else $error("disabled move did not use bus");
	a_hit_internal: assert property (@(posedge clk_sys)
		disable iff (!rst_n) clk_en && xst_q == X_IDLE && xmove_valid
		&& hit |=> int_q)
		else $error("on_chip_xdata_ram hit routed outside");
	a_code_source: assert property (@(posedge clk_sys)
		disable iff (!rst_n) clk_en |=> code_from_external ==
		$past(!ea_q || pc > ROM_TOP))
		else $error("wrong code fetch source");
	a_sp_push: assert property (@(posedge clk_sys)
		disable iff (!rst_n) clk_en && stack_push |=>
		sp_q == $past(sp_q) + 8'h01)
		else $error("stack pointer not pre-incremented");
	a_bit_write: assert property (@(posedge clk_sys)
		disable iff (!rst_n) ram_go && ram_write && ram_mode == AM_BIT
		&& !ram_addr[7] |=> iram_q[$past(eff)][$past(ram_addr[2:0])]
		== $past(ram_bit_value))
		else $error("bit write missed its byte");
endmodule : on_chip_xdata_ram_access_memory_map

// ==== rtl/on_chip_xdata_ram_if.sv ====
// port bundle between the address-map block and the on-chip data store
// assumes the store answers a read on the edge after the request
`timescale 1ns/1ps
interface on_chip_xdata_ram_if #(parameter int AW = 11);
	logic          en;
	logic          we;
	logic [AW-1:0] addr;
	logic [7:0]    wdata;
	logic [7:0]    rdata;
	modport host  (output en, we, addr, wdata, input rdata);
	modport store (input en, we, addr, wdata, output rdata);
endinterface : on_chip_xdata_ram_if

// ==== rtl/on_chip_xdata_ram_store.sv ====
// on-chip external-data ram built from flip-flops
// assumes requests come from the address-map block on the same clock
`timescale 1ns/1ps
module on_chip_xdata_ram_store #(
	parameter int DEPTH = 2048
) (
	input wire logic clk_sys,
	input wire logic clk_en,
	on_chip_xdata_ram_if.store    xr
);
	// contents have no reset: they survive a device reset
	logic [7:0] mem_q [0:DEPTH-1];
	always_ff @(posedge clk_sys) begin
		if (clk_en && xr.en) begin
			if (xr.we) begin
				mem_q[xr.addr] <= xr.wdata;
			end else begin
				xr.rdata <= mem_q[xr.addr];
			end
		end
	end
endmodule : on_chip_xdata_ram_store

// ==== rtl/xmap_pkg.sv ====
// constants and types shared by the address-map block and its helpers
// assumes one system clock; the SYSTEM_CONTROL_ADDR, PSW_ADDR, SP_ADDR and B_ADDR offsets are special register addresses
package xmap_pkg;
	localparam int   DATA_W       = 8;
	localparam int   ON_CHIP_XDATA_RAM_AW      = 11;
	localparam int   IRAM_DEPTH   = 256;
	localparam int   PHASES       = 12;
	// special register addresses
	localparam logic [7:0] SYSTEM_CONTROL_ADDR = 8'hB1;
	localparam logic [7:0] PSW_ADDR    = 8'hD0;
	localparam logic [7:0] SP_ADDR     = 8'h81;
	localparam logic [7:0] B_ADDR      = 8'hF0;
	// field positions and reset values
	localparam int   XD_BIT       = 0;
	localparam int   XV_BIT       = 1;
	localparam int   BANK_LO      = 3;
	localparam int   BANK_HI      = 4;
	localparam logic [7:0] SYSTEM_CONTROL_RESET = 8'h01;
	localparam logic [7:0] PSW_RESET    = 8'h00;
	localparam logic [7:0] SP_RESET     = 8'h07;
	localparam logic [7:0] B_RESET      = 8'h00;
	// address map
	localparam logic [15:0] ON_CHIP_XDATA_RAM_BASE = 16'hF800;
	localparam logic [15:0] ROM_TOP   = 16'h7FFF;
	localparam logic [7:0]  BIT_BASE  = 8'h20;
	// phase numbers within a machine cycle, S1P1 is zero
	localparam logic [3:0] PH_S1P2 = 4'h1;
	localparam logic [3:0] PH_S2P1 = 4'h2;
	localparam logic [3:0] PH_S4P1 = 4'h6;
	localparam logic [3:0] PH_S4P2 = 4'h7;
	localparam logic [3:0] PH_S5P1 = 4'h8;
	localparam logic [3:0] PH_S6P2 = 4'hB;
	// bus strobe width
	localparam int CLK_NS     = 5;
	localparam int STROBE_NS  = 20;
	localparam int STROBE_CYC = (STROBE_NS + CLK_NS - 1) / CLK_NS;
	typedef enum logic [1:0] {
		AM_DIRECT, AM_INDIRECT, AM_REGISTER, AM_BIT
	} ram_mode_t;
	typedef enum logic [1:0] {
		X_IDLE, X_ADDR, X_STRB, X_DONE
	} xbus_state_t;
endpackage : xmap_pkg

// ==== test/ext_mem_model.sv ====
// external program/data memory on the multiplexed port 0/2 bus
// assumes strobes and port outputs come straight from the block
`timescale 1ns/1ps
module ext_mem_model (
	input  wire logic       clk_sys,
	input  wire logic       rd_n,
	input  wire logic       wr_n,
	input  wire logic       p0_oe,
	input  wire logic [7:0] p0_out,
	input  wire logic [7:0] p2_out,
	input  wire logic       slow,
	output logic      [7:0] bus_val
);
	// ---------------------------------------------
	// address latch and storage
	// ---------------------------------------------
	logic [7:0]  mem [0:65535];
	logic [15:0] adr_q;
	logic        rd_q = 1'b1;
	logic [7:0]  last_q = 8'h00;
	always_ff @(posedge clk_sys) begin
		if (rd_n && wr_n && p0_oe)
			adr_q <= {p2_out, p0_out};
	end
	always_ff @(posedge clk_sys) begin
		if (!wr_n)
			mem[adr_q] <= p0_out;
	end
	// a released bus flips every cycle so a stale byte never matches;
	// slow mode keeps the byte one cycle past the strobe (long hold);
	// data must already stand in the first strobe cycle for the filter
	always_ff @(posedge clk_sys) begin
		rd_q <= rd_n;
		last_q <= bus_val;
	end
	assign bus_val = (!rd_n || (slow && !rd_q)) ? mem[adr_q] : ~last_q;
endmodule : ext_mem_model

// ==== test/on_chip_xdata_ram_access_memory_map_tb_top.sv ====
// self-checking bench for the address-map block
// assumes ext_mem_model answers bus cycles on port 0
`timescale 1ns/1ps
module on_chip_xdata_ram_access_memory_map_tb_top import xmap_pkg::*;;
	logic        clk_sys = 1'b0;
	logic        rst_n = 1'b0;
	logic        ea_pin = 1'b1;
	logic        two_b = 1'b0;
	logic        slow = 1'b0;
	logic        ce = 1'b1;
	logic [15:0] pc = 16'h0000;
	logic        ram_valid = 1'b0, ram_write = 1'b0, bitv = 1'b0;
	ram_mode_t   ram_mode = AM_DIRECT;
	logic [7:0]  ram_addr = 8'h00, ram_wdata = 8'h00;
	logic        push = 1'b0, pop = 1'b0, mdw = 1'b0;
	logic [7:0]  push_d = 8'h00, mdb = 8'h00;
	logic        xv = 1'b0, xw = 1'b0;
	logic [15:0] xa = 16'h0000;
	logic [7:0]  xd = 8'h00;
	logic        code_ext, ale, opl, opf, pca, cend;
	logic [7:0]  ram_rdata, b_value, xmove_rdata, p0_out, p0_in, p2_out;
	logic [7:0]  bus_val, x_q, x_hi;
	logic        ram_rvalid, ram_fault, xmove_done, rd_n, wr_n;
	logic        p0_oe, p2_oe, flt, x_st;
	int          x_n, fails = 0, samples_checked = 0, cyc = 0;

	assign p0_in = p0_oe ? p0_out : bus_val;

	on_chip_xdata_ram_access_memory_map uut (.clk_sys(clk_sys), .rst_n(rst_n),
		.clk_en(ce), .external_access_pin(ea_pin), .pc(pc),
		.two_byte_op(two_b), .code_from_external(code_ext), .ale(ale),
		.opcode_latch(opl), .operand_fetch(opf), .pc_advance(pca),
		.cycle_end(cend), .ram_valid(ram_valid), .ram_write(ram_write),
		.ram_mode(ram_mode), .ram_addr(ram_addr), .ram_wdata(ram_wdata),
		.ram_bit_value(bitv), .stack_push(push), .stack_pop(pop),
		.stack_wdata(push_d), .muldiv_wr(mdw), .muldiv_b(mdb),
		.ram_rdata(ram_rdata), .ram_rvalid(ram_rvalid),
		.ram_fault(ram_fault), .b_value(b_value), .xmove_valid(xv),
		.xmove_write(xw), .xmove_addr(xa), .xmove_wdata(xd),
		.xmove_rdata(xmove_rdata), .xmove_done(xmove_done),
		.ext_rd_n(rd_n), .ext_wr_n(wr_n), .p0_out(p0_out), .p0_oe(p0_oe),
		.p0_in(p0_in), .p2_out(p2_out), .p2_oe(p2_oe));
	ext_mem_model ext (.clk_sys(clk_sys), .rd_n(rd_n), .wr_n(wr_n),
		.p0_oe(p0_oe), .p0_out(p0_out), .p2_out(p2_out), .slow(slow),
		.bus_val(bus_val));

	initial forever #2.5 clk_sys = ~clk_sys;
	// cut a hang short well beyond the few hundred cycles needed
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 20000) begin
			fails++;
			end_of_test();
		end
	end

	// ---------------------------------------------
	// bus and compare helpers
	// ---------------------------------------------
	task automatic chk(input string nm, input logic [15:0] got, exp);
		samples_checked++;
		if (got !== exp) begin
			fails++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	task automatic rop(input logic w, input ram_mode_t m,
		input logic [7:0] a, d, output logic [7:0] q);
		q = 'x;
		flt = 1'b0;
		ram_valid <= 1'b1;
		ram_write <= w;
		ram_mode <= m;
		ram_addr <= a;
		ram_wdata <= d;
		bitv <= d[0];
		@(posedge clk_sys);
		ram_valid <= 1'b0;
		repeat (3) begin
			@(posedge clk_sys);
			if (ram_rvalid)
				q = ram_rdata;
			if (ram_fault)
				flt = 1'b1;
		end
	endtask : rop
	task automatic xmv(input logic w, input logic [15:0] a,
		input logic [7:0] d);
		x_st = 1'b0;
		x_n = 0;
		xv <= 1'b1;
		xw <= w;
		xa <= a;
		xd <= d;
		@(posedge clk_sys);
		xv <= 1'b0;
		for (int k = 1; k < 20 && x_n == 0; k++) begin
			@(posedge clk_sys);
			if (!rd_n || !wr_n || p2_oe) begin
				x_st = 1'b1;
				x_hi = p2_out;
			end
			if (xmove_done) begin
				x_n = k;
				x_q = xmove_rdata;
			end
		end
	endtask : xmv
	task automatic stk(input logic p, input logic [7:0] d,
		output logic [7:0] q);
		push <= p;
		pop <= !p;
		push_d <= d;
		@(posedge clk_sys);
		push <= 1'b0;
		pop <= 1'b0;
		@(posedge clk_sys);
		q = ram_rdata;
		@(posedge clk_sys);
	endtask : stk

	// ---------------------------------------------
	// scenarios
	// ---------------------------------------------
	task automatic t_reset;
		logic [7:0] q;
		rop(0, AM_DIRECT, 8'hB1, 8'h00, q);
		chk("sysctl", {8'h00, q & 8'h03}, 16'h0001);
		rop(0, AM_DIRECT, 8'h81, 8'h00, q);
		chk("sp", q, 16'h0007);
		stk(1'b1, 8'h3C, q);
		rop(0, AM_DIRECT, 8'h81, 8'h00, q);
		chk("sp push", q, 16'h0008);
		rop(0, AM_DIRECT, 8'h08, 8'h00, q);
		chk("first push", q, 16'h003C);
		stk(1'b0, 8'h00, q);
		chk("pop", q, 16'h003C);
		rop(0, AM_DIRECT, 8'h81, 8'h00, q);
		chk("sp pop", q, 16'h0007);
	endtask : t_reset
	task automatic t_on_chip_xdata_ram;
		logic [7:0] q;
		xmv(1, 16'hF900, 8'h5A);
		chk("dis strobe", x_st, 1);
		chk("bus time", x_n, 3 + STROBE_CYC);
		xmv(1, 16'hF800, 8'h11);
		slow <= 1'b1;
		xmv(0, 16'hF900, 8'h00);
		slow <= 1'b0;
		chk("dis read", x_q, 16'h005A);
		rop(1, AM_DIRECT, 8'hB1, 8'h00, q);
		xmv(1, 16'hF800, 8'hA5);
		chk("hid strobe", x_st, 0);
		chk("hid time", x_n, 3);
		chk("ext kept", ext.mem[16'hF800], 16'h0011);
		xmv(1, 16'hFFFF, 8'h3E);
		xmv(0, 16'hFFFF, 8'h00);
		chk("top byte", x_q, 16'h003E);
		xmv(1, 16'hF7FF, 8'h77);
		chk("below base", x_st, 1);
		rop(1, AM_DIRECT, 8'hB1, 8'hFD, q);
		rop(0, AM_DIRECT, 8'hB1, 8'h00, q);
		chk("no reset", {8'h00, q & 8'h03}, 16'h0000);
		xmv(0, 16'hF800, 8'h00);
		chk("still hid", {x_st, x_q}, 16'h00A5);
		rop(1, AM_DIRECT, 8'hB1, 8'h02, q);
		xmv(0, 16'hF800, 8'h00);
		chk("vis read", {x_st, x_q}, 16'h01A5);
		chk("vis addr", x_hi, 16'h00F8);
		xmv(1, 16'h1234, 8'hC3);
		chk("out time", x_n, 3 + STROBE_CYC);
		slow <= 1'b1;
		xmv(0, 16'h1234, 8'h00);
		slow <= 1'b0;
		chk("out read", {x_st, x_q}, 16'h01C3);
		rop(1, AM_DIRECT, 8'hB1, 8'h00, q);
	endtask : t_on_chip_xdata_ram
	task automatic t_code;
		pc <= 16'h7FFF;
		repeat (8) @(posedge clk_sys);
		chk("rom top", code_ext, 0);
		pc <= 16'h8000;
		repeat (3) @(posedge clk_sys);
		chk("ext code", code_ext, 1);
		ea_pin <= 1'b0;
		pc <= 16'h0000;
		repeat (8) @(posedge clk_sys);
		chk("pin low", code_ext, 1);
	endtask : t_code
	task automatic t_ram;
		logic [7:0] q;
		rop(1, AM_DIRECT, 8'hD0, 8'h08, q);
		rop(1, AM_REGISTER, 8'h00, 8'h90, q);
		rop(0, AM_DIRECT, 8'h08, 8'h00, q);
		chk("bank1 r0", q, 16'h0090);
		rop(1, AM_INDIRECT, 8'h00, 8'h5D, q);
		rop(0, AM_INDIRECT, 8'h00, 8'h00, q);
		chk("upper ind", q, 16'h005D);
		rop(0, AM_DIRECT, 8'h90, 8'h00, q);
		chk("upper dir", flt, 1);
		rop(1, AM_DIRECT, 8'hD0, 8'h00, q);
		rop(1, AM_DIRECT, 8'h21, 8'h00, q);
		rop(1, AM_BIT, 8'h0B, 8'h01, q);
		rop(0, AM_DIRECT, 8'h21, 8'h00, q);
		chk("bit byte", q, 16'h0008);
		rop(0, AM_BIT, 8'h0B, 8'h00, q);
		chk("bit read", q[0], 1);
		mdw <= 1'b1;
		mdb <= 8'hC7;
		@(posedge clk_sys);
		mdw <= 1'b0;
		repeat (2) @(posedge clk_sys);
		chk("b muldiv", b_value, 16'h00C7);
		rop(1, AM_DIRECT, 8'hF0, 8'h2B, q);
		rop(0, AM_DIRECT, 8'hF0, 8'h00, q);
		chk("b scratch", q, 16'h002B);
		ce <= 1'b0;
		rop(1, AM_DIRECT, 8'hF0, 8'h66, q);
		ce <= 1'b1;
		rop(0, AM_DIRECT, 8'hF0, 8'h00, q);
		chk("frozen", q, 16'h002B);
	endtask : t_ram
	task automatic t_timer;
		int na, nc, no, np, nf;
		na = 0;
		nc = 0;
		no = 0;
		np = 0;
		nf = 0;
		repeat (12) begin
			@(posedge clk_sys);
			na += ale;
			nc += cend;
			no += opl;
			np += pca;
			nf += opf;
		end
		chk("ale phases", na, 4);
		chk("cycle end", nc, 1);
		chk("opcode", no, 1);
		chk("discard", np, 0);
		chk("fetch s4", nf, 1);
		two_b <= 1'b1;
		repeat (12) @(posedge clk_sys);
		np = 0;
		repeat (12) begin
			@(posedge clk_sys);
			np += pca;
		end
		two_b <= 1'b0;
		chk("second byte", np, 1);
	endtask : t_timer
	task automatic t_rerun;
		logic [7:0] q;
		rst_n <= 1'b0;
		repeat (3) @(posedge clk_sys);
		rst_n <= 1'b1;
		repeat (2) @(posedge clk_sys);
		rop(0, AM_DIRECT, 8'hB1, 8'h00, q);
		chk("reset sets", {8'h00, q & 8'h03}, 16'h0001);
		rop(1, AM_DIRECT, 8'hB1, 8'h00, q);
		xmv(0, 16'hF800, 8'h00);
		chk("on_chip_xdata_ram kept", {x_st, x_q}, 16'h00A5);
	endtask : t_rerun

	task automatic end_of_test;
		if (fails == 0 && samples_checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : end_of_test

	initial begin
		repeat (12) @(posedge clk_sys);
		rst_n <= 1'b1;
		repeat (2) @(posedge clk_sys);
		t_reset();
		t_on_chip_xdata_ram();
		t_code();
		t_ram();
		t_timer();
		t_rerun();
		end_of_test();
	end
endmodule : on_chip_xdata_ram_access_memory_map_tb_top
